// ===== hdl/txdp_pkg.sv
package txdp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int REG_AW = 12; // Register address width
  localparam logic [11:0] CTRL_ADDR = 12'h300; // tx_dma_control
  localparam logic [11:0] PROVISION_FLAG_ADDR = 12'h304; // tx_channel_provisioning
  localparam logic [3:0] BE_NONE = 4'hF; // All active-low byte enables negated
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CACHE_BIT = 1;
  localparam int CTRL_RDY_LSB = 2;
  localparam int CTRL_FR_LSB = 5;
  localparam int CTRL_FLUSH_BIT = 7;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic CTRL_CACHE_RST = 1'b1;
  localparam logic [2:0] CTRL_RDY_RST = 3'h0;
  localparam logic [1:0] CTRL_FR_RST = 2'h0;
  localparam logic CTRL_FLUSH_RST = 1'b0;
  // ----------------------------------------------------------------
  // Provisioning register fields
  // ----------------------------------------------------------------
  localparam int PROVISION_FLAG_CHAN_LSB = 0;
  localparam int PROVISION_FLAG_RSV_LSB = 8;
  localparam int PROVISION_FLAG_FLAG_BIT = 13;
  localparam int PROVISION_FLAG_RWB_BIT = 14;
  localparam int PROVISION_FLAG_BUSY_BIT = 15;
  localparam int CHAN_W = 8;
  localparam int CHANS = 256;
  // ----------------------------------------------------------------
  // Timing and thresholds
  // ----------------------------------------------------------------
  localparam logic [1:0] IND_CYC = 2'h2; // Indirect access length in cycles
  localparam int CACHE_DEPTH = 6; // Freed references per cached block
  localparam logic [5:0] RDY_N0 = 6'h01; // Code 000, value unreadable, chosen
  localparam logic [5:0] RDY_N1 = 6'h04;
  localparam logic [5:0] RDY_N2 = 6'h06;
  localparam logic [5:0] RDY_N3 = 6'h08;
  localparam logic [5:0] RDY_N4 = 6'h10;
  localparam logic [5:0] RDY_N5 = 6'h20;
  localparam logic [3:0] FR_N0 = 4'h1;
  localparam logic [3:0] FR_N1 = 4'h4;
  localparam logic [3:0] FR_N2 = 4'h8;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  localparam int TDR_W = 16;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_AW-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] be_n;
  } txdp_reg_req_t;
  typedef struct packed {
    logic rejected;
    logic [TDR_W-1:0] tx_descriptor_reference;
  } txdp_elem_t;
endpackage

// ===== hdl/txdp_free_cache.sv
`timescale 1ns/10ps
`default_nettype none
module txdp_free_cache
  import txdp_pkg::*;
#(
  parameter int DEPTH = CACHE_DEPTH
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cache_en,
  input wire logic flush_req,
  input wire logic in_valid,
  input wire txdp_elem_t in_elem,
  output logic in_ready,
  output logic out_valid,
  output var txdp_elem_t out_elem,
  output logic out_last,
  input wire logic out_ready,
  output logic block_done,
  output logic flush_done
);
  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_C = CW'(1);
  typedef enum logic {FC_FILL = 1'b0, FC_DRAIN = 1'b1} txdp_fc_state_t;
  txdp_fc_state_t state_r; // Fill or drain
  txdp_elem_t mem_r [DEPTH]; // Cached freed references
  logic [CW-1:0] cnt_r; // Entries held
  logic [CW-1:0] rd_r; // Drain position
  logic flushing_r; // Current block was started by a flush
  logic start; // Begin a block write
  // Drain on a full block, at once when caching is off, or on flush
  assign start = (state_r == FC_FILL) && ((cnt_r == DEPTH_C) || (cnt_r != '0 && (!cache_en || flush_req)));
  // Input stalls while a block goes out; keeps block contents fixed
  assign in_ready = (state_r == FC_FILL) && (cnt_r < DEPTH_C) && !start;
  assign out_valid = (state_r == FC_DRAIN);
  assign out_elem = mem_r[rd_r];
  assign out_last = (rd_r == cnt_r - ONE_C);
  assign block_done = out_valid && out_ready && out_last;
  // Empty cache flushes at once
  assign flush_done = ((state_r == FC_FILL) && flush_req && cnt_r == '0) || (block_done && flushing_r);
  // ----------------------------------------------------------------
  // Entry capture
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end
    else if (in_valid && in_ready)
    begin
      mem_r[cnt_r] <= in_elem;
    end
  end
  // ----------------------------------------------------------------
  // Fill and drain sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= FC_FILL;
      cnt_r <= '0;
      rd_r <= '0;
      flushing_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        FC_FILL:
        begin
          if (start)
          begin
            state_r <= FC_DRAIN;
            flushing_r <= flush_req;
            rd_r <= '0;
          end
          else if (in_valid && in_ready)
          begin
            cnt_r <= cnt_r + ONE_C;
          end
        end
        FC_DRAIN:
        begin
          if (out_ready && out_last)
          begin
            state_r <= FC_FILL;
            cnt_r <= '0;
            rd_r <= '0;
            flushing_r <= 1'b0;
          end
          else if (out_ready)
          begin
            rd_r <= rd_r + ONE_C;
          end
        end
        default:
        begin
          state_r <= FC_FILL;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_block_max;
    @(posedge clock) disable iff (!rst_n) cnt_r <= DEPTH_C;
  endproperty
  a_block_max: assert property (p_block_max) else $error("cache holds more than one block");
  property p_single;
    @(posedge clock) disable iff (!rst_n) (state_r == FC_FILL && !cache_en && cnt_r == ONE_C) |=> (out_valid && out_last);
  endproperty
  a_single: assert property (p_single) else $error("uncached reference not written alone");
endmodule
`default_nettype wire

// ===== hdl/txdp_top.sv
// Function
// - Any enabled byte writes whole register
// - All byte enables negated means no access
// - Enable high accepts ready-queue references
// - Enable low ignores ready queue
// - Cache on writes freed references up to six
// - Cache off writes each freed reference alone
// - Ready interrupt after selected reference count
// - Free interrupt after selected block count
// - Flush bit dumps whole free cache
// - Flush self-clears; writing zero does nothing
// - Provisioned channel chains appended to list
// - Unprovisioned chains rejected to free queue
// - Indirect read loads flag field
// - Channel field holds last host write
// - Select bit chooses write or query
// - Busy set on write, cleared at completion
// - Flag provisions, unprovisions, reports state
`timescale 1ns/10ps
`default_nettype none
module txdp_top
  import txdp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire txdp_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic rdy_valid,
  input wire logic [TDR_W-1:0] rdy_tdr,
  output logic rdy_ready,
  output logic fetch_valid,
  output logic [TDR_W-1:0] fetch_tdr,
  input wire logic fetch_ready,
  output logic tx_dma_enable,
  input wire logic chain_valid,
  input wire logic [CHAN_W-1:0] chain_chan,
  input wire logic [TDR_W-1:0] chain_tdr,
  output logic chain_ready,
  output logic append_valid,
  output logic [CHAN_W-1:0] append_chan,
  output logic [TDR_W-1:0] append_tdr,
  input wire logic append_ready,
  input wire logic freed_valid,
  input wire logic [TDR_W-1:0] freed_tdr,
  output logic freed_ready,
  output logic fq_wr_valid,
  output var txdp_elem_t fq_wr_elem,
  output logic fq_wr_last,
  input wire logic fq_wr_ready,
  output logic ready_queue_irq,
  output logic free_queue_irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic {IND_IDLE = 1'b0, IND_RUN = 1'b1} txdp_ind_state_t;
  logic enable_r; // DMA enable
  logic cache_r; // Free write caching
  logic [2:0] ready_threshold_sel_r; // Ready interrupt count code
  logic [1:0] free_threshold_sel_r; // Free interrupt block code
  logic free_cache_flush_r; // Flush request, self clearing
  logic [CHAN_W-1:0] channel_number_r; // Indirect channel
  logic provision_flag_r; // Indirect flag
  logic indirect_read_not_write_r; // Query when high
  logic [1:0] rsv_r; // Plain storage bits
  txdp_ind_state_t ind_state_r; // Indirect access progress
  logic [1:0] ind_cnt_r; // Cycles left in access
  logic [CHANS-1:0] provision_flag_mem_r; // Per-channel provision state
  logic wr_hit; // Write with some byte enabled
  logic ctrl_wr; // Control register write
  logic provision_flag_wr; // Provisioning register write
  logic busy; // Indirect access in flight
  logic ind_done; // Indirect access completes this cycle
  logic fetch_valid_r; // Fetch stage holds a reference
  logic [TDR_W-1:0] fetch_tdr_r; // Reference to fetch
  logic append_valid_r; // Append stage holds a chain
  logic [CHAN_W-1:0] append_chan_r; // Chain channel
  logic [TDR_W-1:0] append_tdr_r; // Chain head reference
  logic chan_provision_flag; // Incoming chain channel provisioned
  logic rej_req; // Incoming chain must be rejected
  logic cache_in_valid; // Cache input request
  logic cache_in_ready; // Cache accepts an entry
  txdp_elem_t cache_in_elem; // Entry offered to cache
  logic block_done; // Free block written
  logic flush_done; // Flush finished
  logic [5:0] rdy_cnt_r; // References since last ready event
  logic [3:0] fr_cnt_r; // Blocks since last free event
  logic ready_irq_r; // Ready event pulse
  logic free_irq_r; // Free event pulse
  logic [31:0] rdata_r; // Read data
  logic rvalid_r; // Read answer
  // ----------------------------------------------------------------
  // Threshold decode
  // ----------------------------------------------------------------
  // Reserved codes give zero; zero limits are skipped, so a wrapped counter stays silent
  function automatic logic [5:0] rdy_limit(input logic [2:0] sel);
    case (sel)
      3'h0: rdy_limit = RDY_N0;
      3'h1: rdy_limit = RDY_N1;
      3'h2: rdy_limit = RDY_N2;
      3'h3: rdy_limit = RDY_N3;
      3'h4: rdy_limit = RDY_N4;
      3'h5: rdy_limit = RDY_N5;
      default: rdy_limit = 6'h00;
    endcase
  endfunction
  function automatic logic [3:0] fr_limit(input logic [1:0] sel);
    case (sel)
      2'h0: fr_limit = FR_N0;
      2'h1: fr_limit = FR_N1;
      2'h2: fr_limit = FR_N2;
      default: fr_limit = 4'h0;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign wr_hit = reg_req.wr && (reg_req.be_n != BE_NONE);
  assign ctrl_wr = wr_hit && (reg_req.addr == CTRL_ADDR);
  // Writes while busy are dropped; host is expected to poll first
  assign provision_flag_wr = wr_hit && (reg_req.addr == PROVISION_FLAG_ADDR) && !busy;
  assign busy = (ind_state_r == IND_RUN);
  assign ind_done = busy && (ind_cnt_r == 2'h0);
  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_r <= CTRL_EN_RST;
      cache_r <= CTRL_CACHE_RST;
      ready_threshold_sel_r <= CTRL_RDY_RST;
      free_threshold_sel_r <= CTRL_FR_RST;
    end
    else if (ctrl_wr)
    begin
      enable_r <= reg_req.wdata[CTRL_EN_BIT];
      cache_r <= reg_req.wdata[CTRL_CACHE_BIT];
      ready_threshold_sel_r <= reg_req.wdata[CTRL_RDY_LSB +: 3];
      free_threshold_sel_r <= reg_req.wdata[CTRL_FR_LSB +: 2];
    end
  end
  // Flush bit: a new set in the completion cycle wins over the clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      free_cache_flush_r <= CTRL_FLUSH_RST;
    else if (ctrl_wr && reg_req.wdata[CTRL_FLUSH_BIT])
      free_cache_flush_r <= 1'b1;
    else if (flush_done)
      free_cache_flush_r <= 1'b0;
  end
  // ----------------------------------------------------------------
  // Indirect provisioning register and sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel_number_r <= '0;
      provision_flag_r <= 1'b0;
      indirect_read_not_write_r <= 1'b0;
      rsv_r <= 2'h0;
    end
    else if (provision_flag_wr)
    begin
      // Channel and flag arrive with the trigger write itself
      channel_number_r <= reg_req.wdata[PROVISION_FLAG_CHAN_LSB +: CHAN_W];
      provision_flag_r <= reg_req.wdata[PROVISION_FLAG_FLAG_BIT];
      indirect_read_not_write_r <= reg_req.wdata[PROVISION_FLAG_RWB_BIT];
      rsv_r <= reg_req.wdata[PROVISION_FLAG_RSV_LSB +: 2];
    end
    else if (ind_done && indirect_read_not_write_r)
    begin
      channel_number_r <= channel_number_r;
      provision_flag_r <= provision_flag_mem_r[channel_number_r];
    end
  end
  // Access sequencing; busy is the run state itself
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ind_state_r <= IND_IDLE;
      ind_cnt_r <= 2'h0;
    end
    else
    begin
      case (ind_state_r)
        IND_IDLE:
        begin
          if (provision_flag_wr)
          begin
            ind_state_r <= IND_RUN;
            ind_cnt_r <= IND_CYC - 2'h1;
          end
        end
        IND_RUN:
        begin
          if (ind_cnt_r == 2'h0)
            ind_state_r <= IND_IDLE;
          else
            ind_cnt_r <= ind_cnt_r - 2'h1;
        end
        default:
        begin
          ind_state_r <= IND_IDLE;
        end
      endcase
    end
  end
  // Provision memory; all channels start unprovisioned
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      provision_flag_mem_r <= '0;
    else if (ind_done && !indirect_read_not_write_r)
      provision_flag_mem_r[channel_number_r] <= provision_flag_r;
  end
  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_req.rd;
      rdata_r <= 32'h0000_0000;
      // No byte enabled: answered, but nothing is read
      if (reg_req.rd && reg_req.be_n != BE_NONE && reg_req.addr == CTRL_ADDR)
        rdata_r <= {24'h00_0000, free_cache_flush_r, free_threshold_sel_r, ready_threshold_sel_r, cache_r, enable_r};
      else if (reg_req.rd && reg_req.be_n != BE_NONE && reg_req.addr == PROVISION_FLAG_ADDR)
        rdata_r <= {16'h0000, busy, indirect_read_not_write_r, provision_flag_r, 3'h0, rsv_r, channel_number_r};
    end
  end
  // ----------------------------------------------------------------
  // Ready queue intake
  // ----------------------------------------------------------------
  assign rdy_ready = enable_r && (!fetch_valid_r || fetch_ready);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_valid_r <= 1'b0;
      fetch_tdr_r <= '0;
    end
    else if (rdy_valid && rdy_ready)
    begin
      fetch_valid_r <= 1'b1;
      fetch_tdr_r <= rdy_tdr;
    end
    else if (fetch_ready)
    begin
      fetch_valid_r <= 1'b0;
    end
  end
  // Ready event counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdy_cnt_r <= 6'h00;
      ready_irq_r <= 1'b0;
    end
    else
    begin
      ready_irq_r <= 1'b0;
      if (rdy_valid && rdy_ready)
      begin
        if (rdy_limit(ready_threshold_sel_r) != 6'h00 && rdy_cnt_r + 6'h01 == rdy_limit(ready_threshold_sel_r))
        begin
          ready_irq_r <= 1'b1;
          rdy_cnt_r <= 6'h00;
        end
        else
          rdy_cnt_r <= rdy_cnt_r + 6'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // Chain intake: append or reject
  // ----------------------------------------------------------------
  assign chan_provision_flag = provision_flag_mem_r[chain_chan];
  assign rej_req = chain_valid && !chan_provision_flag;
  assign chain_ready = chan_provision_flag ? (!append_valid_r || append_ready) : cache_in_ready;
  // Rejections take priority over ordinary freed references
  assign cache_in_valid = rej_req || freed_valid;
  assign cache_in_elem = rej_req ? txdp_elem_t'{rejected: 1'b1, tx_descriptor_reference: chain_tdr} : txdp_elem_t'{rejected: 1'b0, tx_descriptor_reference: freed_tdr};
  assign freed_ready = cache_in_ready && !rej_req;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      append_valid_r <= 1'b0;
      append_chan_r <= '0;
      append_tdr_r <= '0;
    end
    else if (chain_valid && chan_provision_flag && chain_ready)
    begin
      append_valid_r <= 1'b1;
      append_chan_r <= chain_chan;
      append_tdr_r <= chain_tdr;
    end
    else if (append_ready)
    begin
      append_valid_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Free queue cache
  // ----------------------------------------------------------------
  txdp_free_cache #(.DEPTH(CACHE_DEPTH)) u_cache (
    .clock(clock),
    .rst_n(rst_n),
    .cache_en(cache_r),
    .flush_req(free_cache_flush_r),
    .in_valid(cache_in_valid),
    .in_elem(cache_in_elem),
    .in_ready(cache_in_ready),
    .out_valid(fq_wr_valid),
    .out_elem(fq_wr_elem),
    .out_last(fq_wr_last),
    .out_ready(fq_wr_ready),
    .block_done(block_done),
    .flush_done(flush_done)
  );
  // Free event counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fr_cnt_r <= 4'h0;
      free_irq_r <= 1'b0;
    end
    else
    begin
      free_irq_r <= 1'b0;
      if (block_done)
      begin
        if (fr_limit(free_threshold_sel_r) != 4'h0 && fr_cnt_r + 4'h1 == fr_limit(free_threshold_sel_r))
        begin
          free_irq_r <= 1'b1;
          fr_cnt_r <= 4'h0;
        end
        else
          fr_cnt_r <= fr_cnt_r + 4'h1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign fetch_valid = fetch_valid_r;
  assign fetch_tdr = fetch_tdr_r;
  // Downstream keeps draining built lists after enable drops
  assign tx_dma_enable = enable_r;
  assign append_valid = append_valid_r;
  assign append_chan = append_chan_r;
  assign append_tdr = append_tdr_r;
  assign ready_queue_irq = ready_irq_r;
  assign free_queue_irq = free_irq_r;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_be_none;
    (reg_req.wr && reg_req.be_n == BE_NONE) |=> $stable(enable_r) && $stable(cache_r) && $stable(ready_threshold_sel_r) && $stable(free_threshold_sel_r);
  endproperty
  a_be_none: assert property (p_be_none) else $error("write with no byte enabled changed control");
  property p_full_write;
    (reg_req.wr && reg_req.be_n != BE_NONE && reg_req.addr == CTRL_ADDR) |=> (enable_r == $past(reg_req.wdata[CTRL_EN_BIT]) && ready_threshold_sel_r == $past(reg_req.wdata[CTRL_RDY_LSB +: 3]));
  endproperty
  a_full_write: assert property (p_full_write) else $error("control not fully written");
  property p_ignore_ready;
    !enable_r |-> !rdy_ready;
  endproperty
  a_ignore_ready: assert property (p_ignore_ready) else $error("ready queue taken while disabled");
  property p_take_ready;
    (enable_r && !fetch_valid_r && rdy_valid) |=> (fetch_valid_r && fetch_tdr_r == $past(rdy_tdr));
  endproperty
  a_take_ready: assert property (p_take_ready) else $error("ready reference not taken");
  property p_flush_hold;
    (free_cache_flush_r && !flush_done) |=> free_cache_flush_r;
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("flush cleared early");
  property p_flush_clear;
    (flush_done && !(ctrl_wr && reg_req.wdata[CTRL_FLUSH_BIT])) |=> !free_cache_flush_r;
  endproperty
  a_flush_clear: assert property (p_flush_clear) else $error("flush did not self clear");
  property p_busy_span;
    provision_flag_wr |=> busy [*2] ##1 !busy;
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy span wrong");
  property p_reject;
    (chain_valid && !provision_flag_mem_r[chain_chan]) |-> (cache_in_valid && cache_in_elem.rejected && cache_in_elem.tx_descriptor_reference == chain_tdr);
  endproperty
  a_reject: assert property (p_reject) else $error("unprovisioned chain not rejected");
  property p_query;
    (ind_done && indirect_read_not_write_r) |=> (provision_flag_r == provision_flag_mem_r[channel_number_r]);
  endproperty
  a_query: assert property (p_query) else $error("query flag wrong");
  property p_ready_restart;
    ready_irq_r |-> (rdy_cnt_r == 6'h00);
  endproperty
  a_ready_restart: assert property (p_ready_restart) else $error("ready counter not restarted");
endmodule
`default_nettype wire

// ===== verification/txdp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host memory side with random stalls
module txdp_host_model
(
  input wire logic clock,
  output logic fetch_ready,
  output logic append_ready,
  output logic fq_wr_ready
);
  int seed = 32'h230D1EC7; // Stall pattern seed
  initial {fetch_ready, append_ready, fq_wr_ready} = 3'h7;
  // Stalls force the engine to hold requests
  always @(posedge clock)
    {fetch_ready, append_ready, fq_wr_ready} <= 3'($random(seed));
endmodule
`default_nettype wire

// ===== verification/test_tx_dma_control_provisioning.sv
`timescale 1ns/10ps
`default_nettype none
module test_tx_dma_control_provisioning
  import txdp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic clock = 1'b0, rst_n = 1'b0, rdy_valid = 1'b0, chain_valid = 1'b0, freed_valid = 1'b0;
  logic [15:0] rdy_tdr = '0, chain_tdr = '0, freed_tdr = '0, fetch_tdr, append_tdr;
  logic [7:0] chain_chan = '0, append_chan;
  logic [31:0] reg_rdata;
  logic reg_rvalid, rdy_ready, fetch_valid, fetch_ready, tx_dma_enable, chain_ready, append_valid;
  logic append_ready, freed_ready, fq_wr_valid, fq_wr_last, fq_wr_ready, ready_queue_irq, free_queue_irq;
  txdp_reg_req_t reg_req = '0;
  txdp_elem_t fq_wr_elem;
  int seed = 32'h230D1EC7, n_errors = 0, checked = 0, n_rdy = 0, n_rirq = 0, n_firq = 0;
  logic [17:0] fq_q[$]; // Free-queue writes seen, with last flag
  logic [23:0] ap = '0; // Last appended chain
  logic [15:0] rq[$]; // Ready references awaiting fetch
  always #10 clock = ~clock;
  txdp_host_model far (.clock, .fetch_ready, .append_ready, .fq_wr_ready);
  txdp_top dut (.clock, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .rdy_valid, .rdy_tdr, .rdy_ready,
    .fetch_valid, .fetch_tdr, .fetch_ready, .tx_dma_enable, .chain_valid, .chain_chan, .chain_tdr,
    .chain_ready, .append_valid, .append_chan, .append_tdr, .append_ready, .freed_valid, .freed_tdr,
    .freed_ready, .fq_wr_valid, .fq_wr_elem, .fq_wr_last, .fq_wr_ready, .ready_queue_irq, .free_queue_irq);
  // Monitor: handshakes and event pulses
  always @(posedge clock)
  begin
    if (rdy_valid && rdy_ready) n_rdy++;
    if (rdy_valid && rdy_ready) rq.push_back(rdy_tdr);
    if (fetch_valid && fetch_ready) chk(fetch_tdr, rq.pop_front());
    if (fq_wr_valid && fq_wr_ready) fq_q.push_back({fq_wr_last, fq_wr_elem});
    if (append_valid && append_ready) ap <= {append_chan, append_tdr};
    if (ready_queue_irq) n_rirq++;
    if (free_queue_irq) n_firq++;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clock);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d, be_n: b};
    @(posedge clock);
    reg_req <= '0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, '0, 4'h0);
    chk(reg_rvalid === 1'b1 ? reg_rdata : ~e, e);
  endtask
  // Busy polling, bounded
  task automatic poll(input logic [31:0] e);
    repeat (8)
    begin
      bus(0, PROVISION_FLAG_ADDR, '0, 4'h0);
      if (reg_rdata[15] === 1'b0) break;
    end
    chk(reg_rdata, e);
  endtask
  // Chain (k=1) or freed reference (k=0); data scrambled once released
  task automatic offer(input logic k, input logic [7:0] c, input logic [15:0] t);
    @(posedge clock);
    chain_valid <= k;
    freed_valid <= !k;
    chain_chan <= c;
    chain_tdr <= t;
    freed_tdr <= t;
    do @(negedge clock); while ((k ? chain_ready : freed_ready) !== 1'b1);
    @(posedge clock);
    chain_valid <= 1'b0;
    freed_valid <= 1'b0;
    chain_tdr <= ~t;
    freed_tdr <= ~t;
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog: far beyond the expected run
  initial
  begin
    #400000;
    n_errors++;
    give_verdict;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(CTRL_ADDR, 32'h2);
    rd(PROVISION_FLAG_ADDR, 32'h0);
    bus(1, CTRL_ADDR, 32'h1D, BE_NONE);
    rd(CTRL_ADDR, 32'h2);
    bus(1, CTRL_ADDR, 32'h5, 4'h7);
    rd(CTRL_ADDR, 32'h5);
    chk(tx_dma_enable, 1);
    repeat (80) @(posedge clock) {rdy_valid, rdy_tdr} <= 17'($random(seed));
    @(posedge clock) rdy_valid <= 1'b0;
    repeat (4) @(posedge clock);
    chk(n_rirq, n_rdy / 4);
    bus(1, CTRL_ADDR, 32'h0, 4'h0);
    @(posedge clock) rdy_valid <= 1'b1;
    @(negedge clock) chk(rdy_ready, 0);
    @(posedge clock) rdy_valid <= 1'b0;
    bus(1, PROVISION_FLAG_ADDR, 32'h2005, 4'hE);
    poll(32'h2005);
    bus(1, PROVISION_FLAG_ADDR, 32'h4005, 4'hE);
    poll(32'h6005);
    bus(1, PROVISION_FLAG_ADDR, 32'h4006, 4'hE);
    poll(32'h4006);
    offer(1, 8'h05, 16'h1234);
    offer(1, 8'h06, 16'h00AB);
    repeat (20) @(posedge clock);
    chk(ap, 32'h51234);
    chk(fq_q.pop_front(), 32'h300AB);
    bus(1, CTRL_ADDR, 32'h2, 4'h0);
    for (int i = 1; i < 9; i++) offer(0, 8'h0, 16'(i));
    repeat (30) @(posedge clock);
    chk(fq_q.size(), 6);
    for (int i = 1; i < 7; i++) chk(fq_q.pop_front(), {i == 6, 17'(i)});
    bus(1, CTRL_ADDR, 32'h82, 4'h0);
    repeat (30) @(posedge clock);
    chk(fq_q.pop_front(), 32'h7);
    chk(fq_q.pop_front(), 32'h20008);
    rd(CTRL_ADDR, 32'h2);
    chk(n_firq, 3);
    give_verdict;
  end
endmodule
`default_nettype wire
